/* File: rtl/wiper_device.sv */
// Purpose: Dual 8-bit wiper device with nonvolatile store, serial control
// Assumes: Link clock is far slower than mclk_i and sampled twice
// Notes:   Busy time is a parameter so simulation can shorten it
`timescale 1ns/1ps
module wiper_device
    import wiper_link_pkg::*;
#(
    parameter logic [BUSY_W-1:0] BUSY_CNT = BUSY_W'(BUSY_CYCLES)
)(
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic              supply_low_i,
    wiper_link_if.device_mp        link,
    output logic [DATA_W-1:0]      wiper_output_one_o,
    output logic [DATA_W-1:0]      wiper_output_two_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_SHIFT = 4'h2,
        ST_HOLD  = 4'h4,
        ST_BUSY  = 4'h8
    } dev_state_t;

    typedef struct packed {
        logic [1:0]        sel_s;
        logic [1:0]        clk_s;
        logic [1:0]        din_s;
        logic [1:0]        req_s;
        logic [1:0]        low_s;
        logic              clk_prev;
        logic              sel_prev;
        dev_state_t        st;
        logic [3:0]        bit_cnt;
        logic              addr0;
        logic [DATA_W-1:0] shift_in;
        logic [DATA_W-1:0] shift_out;
        logic [1:0]        hold_cnt;
        logic              store_seen;
        logic [DATA_W-1:0] store_request_data;
        logic              store_request_addr;
        logic [BUSY_W-1:0] busy_cnt;
        logic [DATA_W-1:0] nv1;
        logic [DATA_W-1:0] nv2;
        logic [DATA_W-1:0] w1;
        logic [DATA_W-1:0] w2;
        logic              dout;
        logic              dout_oe;
        logic              done_flag;
    } dev_reg_t;

    dev_reg_t q;
    dev_reg_t d;

    logic sel;
    logic rise;
    logic sel_fall;

    assign sel      = q.sel_s[1];
    assign rise     = q.clk_s[1] & ~q.clk_prev;
    assign sel_fall = q.sel_prev & ~sel;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        d          = q;
        d.sel_s    = {q.sel_s[0], link.select};
        d.clk_s    = {q.clk_s[0], link.sclk};
        d.din_s    = {q.din_s[0], link.serial_in};
        d.req_s    = {q.req_s[0], link.store_request};
        d.low_s    = {q.low_s[0], supply_low_i};
        d.clk_prev = q.clk_s[1];
        d.sel_prev = sel;
        d.dout_oe  = sel && (q.st != ST_BUSY);
        if (q.req_s[1] && q.st != ST_IDLE && q.st != ST_BUSY)
        begin
            d.store_seen = 1'b1;
        end
        case (q.st)
            ST_IDLE:
            begin
                if (sel && rise && q.din_s[1] == START_VAL)
                begin
                    d.st         = ST_SHIFT;
                    d.bit_cnt    = 4'h1;
                    d.store_seen = q.req_s[1];
                end
            end
            ST_SHIFT:
            begin
                if (!sel)
                begin
                    d.st = ST_IDLE;
                end
                else if (rise)
                begin
                    d.bit_cnt = q.bit_cnt + 4'h1;
                    if (q.bit_cnt == ADDR0_POS)
                    begin
                        d.addr0     = q.din_s[1];
                        d.shift_out = (q.din_s[1] == ADDR0_WIPER2) ? q.w2 : q.w1;
                    end
                    if (q.bit_cnt >= DATA_POS)
                    begin
                        d.shift_in = {q.din_s[1], q.shift_in[DATA_W-1:1]};
                        d.dout      = q.shift_out[0];
                        d.shift_out = {1'b0, q.shift_out[DATA_W-1:1]};
                    end
                    if (q.bit_cnt == FRAME_BITS_C - 4'h1)
                    begin
                        d.st        = ST_HOLD;
                        d.hold_cnt  = 2'h0;
                        d.store_request_data = {q.din_s[1], q.shift_in[DATA_W-1:1]};
                        d.store_request_addr = q.addr0;
                    end
                end
            end
            ST_HOLD:
            begin
                if (q.hold_cnt == 2'h0)
                begin
                    // Output moves one cycle after the last data bit
                    if (q.store_request_addr == ADDR0_WIPER2)
                        d.w2 = q.store_request_data;
                    else
                        d.w1 = q.store_request_data;
                    d.hold_cnt = 2'h1;
                end
                else if (rise || !sel)
                begin
                    d.hold_cnt = q.hold_cnt + 2'h1;
                    if (q.hold_cnt + 2'h1 > DISCARD_CLKS)
                    begin
                        if (q.store_seen && !q.low_s[1])
                        begin
                            d.st        = ST_BUSY;
                            d.busy_cnt  = BUSY_CNT;
                            d.done_flag = 1'b0;
                        end
                        else
                        begin
                            d.st = ST_IDLE;
                        end
                        d.store_seen = 1'b0;
                    end
                end
            end
            ST_BUSY:
            begin
                // Clock and data are ignored until commit; a select fall still reloads the wipers
                if (q.busy_cnt <= BUSY_W'(1))
                begin
                    if (q.store_request_addr == ADDR0_WIPER2)
                        d.nv2 = q.store_request_data;
                    else
                        d.nv1 = q.store_request_data;
                    d.done_flag = 1'b1;
                    d.st        = ST_IDLE;
                end
                else
                begin
                    d.busy_cnt = q.busy_cnt - BUSY_W'(1);
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase
        if (sel_fall)
        begin
            d.w1 = (d.st == ST_BUSY && q.store_request_addr == ADDR0_WIPER1) ? q.store_request_data : d.nv1;
            d.w2 = (d.st == ST_BUSY && q.store_request_addr == ADDR0_WIPER2) ? q.store_request_data : d.nv2;
            if (d.st != ST_BUSY)
            begin
                d.st = ST_IDLE;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q           <= '0;
            q.st        <= ST_IDLE;
            q.nv1       <= NV_RESET1;
            q.nv2       <= NV_RESET2;
            q.w1        <= NV_RESET1;
            q.w2        <= NV_RESET2;
            q.done_flag <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.serial_out      = q.dout;
    assign link.serial_out_oe   = q.dout_oe;
    assign link.store_done_flag = q.done_flag;
    assign wiper_output_one_o   = q.w1;
    assign wiper_output_two_o   = q.w2;
endmodule : wiper_device

/* File: rtl/wiper_host.sv */
// Purpose: Host end that sends one frame per request to the wiper device
// Assumes: Device samples the link with its own 25 MHz clock
// Notes:   Link clock is made here by a divider and driven out
`timescale 1ns/1ps
module wiper_host
    import wiper_link_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic              req_i,
    input  wire logic              channel_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              store_i,
    input  wire logic              end_select_i,
    wiper_link_if.host_mp          link,
    output logic                   busy_o,
    output logic [DATA_W-1:0]      read_data_o,
    output logic                   read_valid_o,
    output logic                   store_done_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [3:0]
    {
        H_IDLE = 4'h1,
        H_SEND = 4'h2,
        H_GAP  = 4'h4,
        H_WAIT = 4'h8
    } host_state_t;

    typedef struct packed {
        logic [1:0]        do_s;
        logic [1:0]        rb_s;
        host_state_t       st;
        logic [5:0]        div;
        logic              sclk;
        logic              sel;
        logic              din;
        logic              store;
        logic [3:0]        bit_cnt;
        logic [10:0]       frame;
        logic [DATA_W-1:0] rd;
        logic              rd_valid;
        logic              busy;
        logic              done;
        logic              seen_low;
        logic              end_sel;
        logic              st_req;
    } host_reg_t;

    host_reg_t q;
    host_reg_t d;
    logic      tick;

    assign tick = (q.div == SCLK_HALF_C - 6'h1);

    always_comb
    begin
        d          = q;
        d.do_s     = {q.do_s[0], link.serial_out};
        d.rb_s     = {q.rb_s[0], link.store_done_flag};
        d.rd_valid = 1'b0;
        d.done     = 1'b0;
        d.div      = tick ? 6'h0 : q.div + 6'h1;
        if (tick && q.st != H_IDLE)
        begin
            d.sclk = ~q.sclk;
            if (!q.sclk)
            begin
                // Rising edge: device samples the bit set up half a period ago
                d.bit_cnt = q.bit_cnt + 4'h1;
            end
            else
            begin
                case (q.st)
                    H_SEND:
                    begin
                        // Read on the fall, so the device's answer to the rise has settled
                        if (q.bit_cnt > DATA_POS)
                            d.rd = {q.do_s[1], q.rd[DATA_W-1:1]};
                        if (q.bit_cnt == FRAME_BITS_C)
                        begin
                            d.st       = H_GAP;
                            d.bit_cnt  = 4'h0;
                            d.rd_valid = 1'b1;
                        end
                        else
                        begin
                            d.din   = q.frame[q.bit_cnt];
                            d.store = q.store | (q.st_req & (q.bit_cnt > 4'h0));
                        end
                    end
                    H_GAP:
                    begin
                        d.din = 1'b0;
                        if (q.bit_cnt[1:0] == IDLE_CLKS)
                        begin
                            d.sel = q.end_sel ? 1'b0 : q.sel;
                            d.st  = q.store ? H_WAIT : H_IDLE;
                            d.busy = q.store;
                            d.seen_low = 1'b0;
                        end
                    end
                    H_WAIT:
                    begin
                        if (!q.rb_s[1])
                            d.seen_low = 1'b1;
                        else if (q.seen_low)
                        begin
                            d.st    = H_IDLE;
                            d.store = 1'b0;
                            d.busy  = 1'b0;
                            d.done  = 1'b1;
                        end
                    end
                    default:
                    begin
                        d.st = H_IDLE;
                    end
                endcase
            end
        end
        if (q.st == H_IDLE)
        begin
            d.sclk  = 1'b0;
            d.store = 1'b0;
            d.busy  = 1'b0;
            if (req_i)
            begin
                d.st      = H_SEND;
                d.sel     = 1'b1;
                d.busy    = 1'b1;
                d.end_sel = end_select_i;
                d.bit_cnt = 4'h0;
                // Start bit stands before the first rise, all eleven bits go on the wire
                d.din     = START_VAL;
                d.st_req  = store_i;
                d.frame   = {data_i, ADDR1_VAL, channel_i, START_VAL};
                d.frame[ADDR0_POS] = channel_i;
                d.frame[ADDR0_POS+4'h1] = ADDR1_VAL;
                d.frame[DATA_POS +: DATA_W] = data_i;
            end
            else if (end_select_i)
            begin
                d.sel = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q    <= '0;
            q.st <= H_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.select        = q.sel;
    assign link.sclk          = q.sclk;
    assign link.serial_in     = q.din;
    assign link.store_request = q.store;
    assign busy_o             = q.busy;
    assign read_data_o        = q.rd;
    assign read_valid_o       = q.rd_valid;
    assign store_done_o       = q.done;
endmodule : wiper_host

/* File: rtl/wiper_link_if.sv */
// Purpose: Pins between host and wiper device
// Assumes: Only the device drives serial out; the host reads it through a two-flop synchronizer
// Notes:   Enable high while the device drives serial out
`timescale 1ns/1ps
interface wiper_link_if;
    logic select;
    logic sclk;
    logic serial_in;
    logic store_request;
    logic serial_out;
    logic serial_out_oe;
    logic store_done_flag;
    modport device_mp (input select, sclk, serial_in, store_request,
                       output serial_out, serial_out_oe, store_done_flag);
    modport host_mp   (output select, sclk, serial_in, store_request,
                       input serial_out, serial_out_oe, store_done_flag);
endinterface : wiper_link_if

/* File: rtl/wiper_link_pkg.sv */
// Purpose: Shared constants for the dual wiper serial link
// Assumes: 25 MHz system clock on both ends
// Notes:   Link clock is sampled, never used as a clock
package wiper_link_pkg;
    localparam int           DATA_W        = 8;
    localparam int           FRAME_BITS    = 11;
    localparam logic [3:0]   FRAME_BITS_C  = 4'hb;
    localparam logic [3:0]   ADDR0_POS     = 4'h1;
    localparam logic [3:0]   DATA_POS      = 4'h3;
    localparam logic         START_VAL     = 1'b1;
    localparam logic         ADDR0_WIPER1  = 1'b0;
    localparam logic         ADDR0_WIPER2  = 1'b1;
    localparam logic         ADDR1_VAL     = 1'b0;
    localparam logic [1:0]   DISCARD_CLKS  = 2'h2;
    localparam logic [1:0]   IDLE_CLKS     = 2'h2;
    localparam logic [7:0]   NV_RESET1     = 8'h80;
    localparam logic [7:0]   NV_RESET2     = 8'h80;
    localparam int           CLK_MHZ       = 25;
    localparam int           CLK_NS        = 40;
    localparam int           BUSY_US       = 5000;
    localparam int           BUSY_CYCLES   = BUSY_US * CLK_MHZ;
    localparam int           SCLK_HALF_NS  = 600;
    localparam int           SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0]   SCLK_HALF_C   = 6'(SCLK_HALF_CYC);
    localparam int           STORE_REQUEST_SETUP_NS = 150;
    localparam int           BUSY_W        = 20;
endpackage : wiper_link_pkg

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the host and device pair
// Assumes: Busy countdown shortened to BUSY_SIM cycles
// Notes:   Low-supply store leaves the host waiting; a reset ends it
`timescale 1ns/1ps
module tb_top;
    import wiper_link_pkg::*;
    localparam logic [BUSY_W-1:0] BUSY_SIM = 20'h32;
    logic             mclk = 1'b0;
    logic             rstn;
    logic             req;
    logic             channel;
    logic [7:0]       data;
    logic             store;
    logic             end_sel;
    logic             supply_low;
    logic             busy;
    logic             rd_valid;
    logic             st_done;
    logic [7:0]       rd_data;
    logic [7:0]       w1;
    logic [7:0]       w2;
    logic [7:0]       rd;
    logic [3:0]       ev;
    int               error_cnt = 0;
    int               num_checks = 0;
    always #20 mclk = ~mclk;
    wiper_link_if link_if();
    wiper_device #(.BUSY_CNT(BUSY_SIM)) wiper_device_inst (.mclk_i(mclk), .rstn_i(rstn),
        .supply_low_i(supply_low), .link(link_if), .wiper_output_one_o(w1),
        .wiper_output_two_o(w2));
    wiper_host wiper_host_inst (.mclk_i(mclk), .rstn_i(rstn), .req_i(req), .channel_i(channel),
        .data_i(data), .store_i(store), .end_select_i(end_sel), .link(link_if), .busy_o(busy),
        .read_data_o(rd_data), .read_valid_o(rd_valid), .store_done_o(st_done));
    wiper_link_assertions #(.BUSY_CNT(BUSY_SIM)) wiper_link_assertions_inst (.mclk_i(mclk),
        .rstn_i(rstn), .select(link_if.select), .sclk(link_if.sclk),
        .serial_in(link_if.serial_in), .store_request(link_if.store_request),
        .serial_out(link_if.serial_out), .serial_out_oe(link_if.serial_out_oe),
        .store_done_flag(link_if.store_done_flag));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic timed_out();
        error_cnt++;
        $display("CHECK FAILED at %0t: wait bound used up", $time);
        complete_run();
    endtask : timed_out
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
    endtask : do_reset
    // Events: 0 read back, 1 store done, 2 busy flag seen low
    task automatic run_frame(input logic ch, input logic [7:0] d, input logic st,
                             input logic es, input logic may_hang);
        int   i;
        int   idle;
        logic went;
        went = 1'b0;
        idle = 0;
        ev = 4'h0;
        rd = 8'h0;
        channel <= ch;
        data <= d;
        store <= st;
        end_sel <= es;
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        for (i = 0; i < 8000 && idle < 40; i++)
        begin
            @(posedge mclk);
            if (rd_valid === 1'b1)
                rd = rd_data;
            ev[0] = ev[0] | (rd_valid === 1'b1);
            ev[1] = ev[1] | (st_done === 1'b1);
            ev[2] = ev[2] | (link_if.store_done_flag === 1'b0);
            went = went | (busy === 1'b1);
            idle = (went && busy === 1'b0) ? idle + 1 : 0;
        end
        if (idle < 40 && !may_hang)
            timed_out();
    endtask : run_frame
    task automatic drop_select();
        int i;
        end_sel <= 1'b1;
        @(posedge mclk);
        end_sel <= 1'b0;
        for (i = 0; i < 100 && link_if.select !== 1'b0; i++)
            @(posedge mclk);
        if (link_if.select !== 1'b0)
            timed_out();
        repeat (8) @(posedge mclk);
    endtask : drop_select
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_power_up();
        check(w1, NV_RESET1);
        check(w2, NV_RESET2);
        check({7'h0, link_if.serial_out_oe}, 8'h0);
        check({7'h0, link_if.store_done_flag}, 8'h1);
    endtask : t_power_up
    // Back-to-back temporary writes; bit-reversal-sensitive codes expose order
    task automatic t_temporary();
        run_frame(1'b0, 8'h35, 1'b0, 1'b0, 1'b0);
        check(rd, NV_RESET1);
        check(w1, 8'h35);
        check(w2, NV_RESET2);
        run_frame(1'b1, 8'hc1, 1'b0, 1'b0, 1'b0);
        check(rd, NV_RESET2);
        check(w2, 8'hc1);
        check(w1, 8'h35);
        run_frame(1'b0, 8'h11, 1'b0, 1'b0, 1'b0);
        check(rd, 8'h35);
        check({7'h0, link_if.serial_out_oe}, 8'h1);
        drop_select();
        check(w1, NV_RESET1);
        check(w2, NV_RESET2);
        check({7'h0, link_if.serial_out_oe}, 8'h0);
    endtask : t_temporary
    task automatic t_store();
        run_frame(1'b1, 8'h42, 1'b0, 1'b0, 1'b0);
        run_frame(1'b0, 8'h96, 1'b1, 1'b1, 1'b0);
        check(rd, NV_RESET1);
        check({7'h0, ev[2]}, 8'h1);
        check({7'h0, ev[1]}, 8'h1);
        check(w1, 8'h96);
        check(w2, NV_RESET2);
    endtask : t_store
    task automatic t_read_only();
        run_frame(1'b0, 8'h0f, 1'b0, 1'b1, 1'b0);
        check(rd, 8'h96);
        check(w1, 8'h96);
    endtask : t_read_only
    // Host may wait on a flag that never drops, so a reset ends this one
    task automatic t_low_supply();
        supply_low <= 1'b1;
        run_frame(1'b1, 8'h5c, 1'b1, 1'b1, 1'b1);
        check({7'h0, ev[2]}, 8'h0);
        check({7'h0, ev[1]}, 8'h0);
        check(w2, NV_RESET2);
        supply_low <= 1'b0;
        do_reset();
        check(w2, NV_RESET2);
    endtask : t_low_supply
    initial
    begin
        rstn = 1'b0;
        req = 1'b0;
        channel = 1'b0;
        data = 8'h0;
        store = 1'b0;
        end_sel = 1'b0;
        supply_low = 1'b0;
        do_reset();
        t_power_up();
        t_temporary();
        t_store();
        t_read_only();
        t_low_supply();
        complete_run();
    end
endmodule : tb_top

/* File: tb/wiper_link_assertions.sv */
// Purpose: Concurrent checks on the link between wiper host and device
// Assumes: All link signals are sampled on mclk_i
// Notes:   BUSY_CNT must match the device instance
`timescale 1ns/1ps
module wiper_link_assertions
    import wiper_link_pkg::*;
#(
    parameter logic [BUSY_W-1:0] BUSY_CNT = 20'h32
)(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic select,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic store_request,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic store_done_flag
);
    // ****************************************
    // Helper counters
    // ****************************************
    logic [11:0]       req_age_q;
    logic [BUSY_W-1:0] low_cnt_q;
    logic [6:0]        still_q;
    // req_age_q and still_q saturate, so a long idle spell never wraps into a false cause
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            req_age_q <= 12'hfff;
            low_cnt_q <= '0;
            still_q   <= '0;
        end
        else
        begin
            req_age_q <= store_request ? 12'h0 : req_age_q + {11'h0, req_age_q != 12'hfff};
            low_cnt_q <= store_done_flag ? '0 : low_cnt_q + 1'b1;
            still_q   <= $changed(sclk) ? 7'h0 : still_q + {6'h0, still_q != 7'h7f};
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_busy;
        !store_done_flag [*2];
    endsequence
    sequence s_selected;
        (select && store_done_flag) [*6];
    endsequence
    property p_oe_off;
        $fell(select) |-> ##[1:5] !serial_out_oe;
    endproperty
    property p_oe_on;
        s_selected |-> serial_out_oe;
    endproperty
    property p_busy_quiet;
        s_busy |-> !serial_out_oe;
    endproperty
    property p_flag_cause;
        $fell(store_done_flag) |-> req_age_q < 12'h7d0;
    endproperty
    property p_busy_len;
        $rose(store_done_flag) |-> low_cnt_q >= BUSY_CNT - 20'h2 && low_cnt_q <= BUSY_CNT + 20'h8;
    endproperty
    property p_out_edge;
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> sclk;
    endproperty
    property p_req_sel;
        $rose(store_request) |-> select;
    endproperty
    property p_sclk_high;
        $rose(sclk) |-> sclk [*8];
    endproperty
    property p_clk_runs;
        !store_done_flag |-> still_q < 7'h40;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("serial out driven after deselect");
    a_oe_on: assert property (p_oe_on) else $error("serial out idle while selected");
    a_busy_quiet: assert property (p_busy_quiet) else $error("serial out driven while busy");
    a_flag_cause: assert property (p_flag_cause) else $error("busy without store request");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_out_edge: assert property (p_out_edge) else $error("serial out moved off clock rise");
    a_req_sel: assert property (p_req_sel) else $error("store request while deselected");
    a_sclk_high: assert property (p_sclk_high) else $error("link clock high phase short");
    a_clk_runs: assert property (p_clk_runs) else $error("link clock stopped while busy");
endmodule : wiper_link_assertions
